// ===== logic/cpu_bus_control.sv
`timescale 1ns/10ps
// Overview of operation
// - Data drivers on only while gate high
// - Low hold halts read cycle, address held
// - Hold ignored in write cycles
// - Unmasked interrupt stacks PC, status, sets mask
// - Maskable vector at FFFE and FFFF
// - Maskable interrupt recognised only while hold high
// - Falling non-maskable edge enters regardless of mask
// - Non-maskable vector at FFFA and FFFB
// - Interrupts sampled phase two, entered at the next fetch request
// - Overflow-set falling edge sets overflow, phase one
// - Opcode marker high through whole fetch cycle
// - Hold low with marker freezes until high
// - No writes while reset is held
// - Six cycles, set mask, vector FFFC/FFFD
// - Absolute address from second and third bytes
// - Zero page high byte zero, index wraps
// - Indexed absolute adds index to base
// - Branch adds signed offset to next address
// - Pre-indexed pointer wraps, reads two bytes
// - Post-indexed adds Y with carry into high
// - Absolute indirect reads pointer pair into PC
module cpu_bus_control
	import cpu_bus_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic data_output_gate,
	input wire logic hold_in,
	input wire logic irq_n,
	input wire logic nmi_n,
	input wire logic ovf_set_n,
	input wire logic [7:0] rd_data,
	input wire cpu_req_s req,
	input wire flag_ctrl_s flag_ctrl,
	output bus_out_s bus,
	output logic data_oe,
	output logic phase_two,
	output cpu_resp_s resp,
	output logic mask_flag,
	output logic ovf_flag
);

	ctl_st_s s_q;
	ctl_st_s s_d;

	function automatic logic is_indirect(input mode_e m);
		is_indirect = (m == M_INDX) || (m == M_INDY) || (m == M_IND);
	endfunction

	// Address of the first pointer byte for the indirect modes
	function automatic logic [15:0] ptr_addr(input cpu_req_s r);
		logic [7:0] zp;
		zp = r.op_lo + r.idx_x;
		case (r.mode)
			M_INDX: ptr_addr = {ZERO_PAGE, zp};
			M_INDY: ptr_addr = {ZERO_PAGE, r.op_lo};
			default: ptr_addr = {r.op_hi, r.op_lo};
		endcase
	endfunction

	// Effective address of the modes that need no pointer read
	function automatic logic [15:0] ea_direct(input cpu_req_s r);
		logic [15:0] base;
		base = {r.op_hi, r.op_lo};
		case (r.mode)
			M_ABS: ea_direct = base;
			M_ZP: ea_direct = {ZERO_PAGE, r.op_lo};
			M_ZPX: ea_direct = {ZERO_PAGE, 8'(r.op_lo + r.idx_x)};
			M_ZPY: ea_direct = {ZERO_PAGE, 8'(r.op_lo + r.idx_y)};
			M_ABSX: ea_direct = base + {8'h00, r.idx_x};
			M_ABSY: ea_direct = base + {8'h00, r.idx_y};
			M_REL: ea_direct = r.pc + {{8{r.op_lo[7]}}, r.op_lo};
			default: ea_direct = r.pc;
		endcase
	endfunction

	logic ph1;
	logic stall;
	logic cyc_end;
	logic int_take;
	logic [15:0] ea_ind;
	logic [7:0] push_status;

	always_comb
	begin
		ph1 = ~s_q.ph;
		// A write cycle never stalls; a low hold waits for the next read
		stall = s_q.bus.rw & (~hold_in | s_q.freeze);
		cyc_end = ~ph1 & ~stall;
		int_take = s_q.nmi_pend | (s_q.irq_lvl & ~s_q.mask);
		ea_ind = {rd_data, s_q.lo};
		if (s_q.rq.mode == M_INDY)
		begin
			ea_ind = {rd_data, s_q.lo} + {8'h00, s_q.rq.idx_y};
		end
		push_status = s_q.rq.status;
		push_status[STATUS_OVF_BIT] = s_q.ovf;
		push_status[STATUS_MASK_BIT] = s_q.mask;

		s_d = s_q;
		s_d.ph = ~s_q.ph;
		s_d.resp.done = 1'b0;
		s_d.resp.int_entry = 1'b0;
		s_d.resp.pc_load = 1'b0;

		if (flag_ctrl.mask_clr)
		begin
			s_d.mask = 1'b0;
		end
		if (flag_ctrl.mask_set)
		begin
			s_d.mask = 1'b1;
		end
		if (flag_ctrl.ovf_clr)
		begin
			s_d.ovf = 1'b0;
		end

		if (hold_in)
		begin
			s_d.freeze = 1'b0;
		end
		else if (ph1 && s_q.bus.marker)
		begin
			s_d.freeze = 1'b1;
		end

		case (s_q.state)
			ST_RST:
			begin
				if (!ph1)
				begin
					if (s_q.init_cnt == RESET_INIT_CYCLES - 3'h1)
					begin
						s_d.mask = 1'b1;
						s_d.vec = VEC_RST;
						s_d.bus.addr = VEC_RST;
						s_d.state = ST_VEC_LO;
					end
					else
					begin
						s_d.init_cnt = s_q.init_cnt + 3'h1;
					end
				end
			end
			ST_IDLE:
			begin
				if (!ph1 && req.valid)
				begin
					s_d.rq = req;
					s_d.bus.rw = 1'b1;
					if (req.kind == K_FETCH && int_take)
					begin
						// Entry replaces the fetch once the instruction ends
						s_d.vec = s_q.nmi_pend ? VEC_NMI : VEC_IRQ;
						if (s_q.nmi_pend)
						begin
							s_d.nmi_pend = 1'b0;
						end
						s_d.sp = req.sp;
						s_d.bus.addr = {STACK_PAGE, req.sp};
						s_d.bus.dout = req.pc[15:8];
						s_d.bus.rw = 1'b0;
						s_d.state = ST_PUSH_H;
					end
					else if (req.kind == K_FETCH)
					begin
						s_d.bus.addr = req.pc;
						s_d.bus.marker = 1'b1;
						s_d.state = ST_FETCH;
					end
					else if (is_indirect(req.mode))
					begin
						s_d.bus.addr = ptr_addr(req);
						s_d.state = ST_PTR_LO;
					end
					else if (req.kind != K_JUMP && req.mode != M_IMPL)
					begin
						s_d.bus.addr = ea_direct(req);
						s_d.resp.ea = ea_direct(req);
						s_d.bus.dout = req.wdata;
						s_d.bus.rw = (req.kind != K_WRITE);
						s_d.state = ST_ACCESS;
					end
					else
					begin
						// Non-indirect jumps and implied requests need no bus cycle
						s_d.resp.done = 1'b1;
						s_d.resp.ea = ea_direct(req);
						s_d.resp.pc = ea_direct(req);
						s_d.resp.pc_load = (req.kind == K_JUMP);
					end
				end
			end
			ST_FETCH:
			begin
				if (cyc_end)
				begin
					s_d.bus.marker = 1'b0;
					s_d.resp.done = 1'b1;
					s_d.resp.rdata = rd_data;
					s_d.state = ST_IDLE;
				end
			end
			ST_PTR_LO:
			begin
				if (cyc_end)
				begin
					s_d.lo = rd_data;
					if (s_q.rq.mode == M_IND)
					begin
						s_d.bus.addr = s_q.bus.addr + 16'h0001;
					end
					else
					begin
						// Pointer pair never leaves page zero
						s_d.bus.addr = {ZERO_PAGE, 8'(s_q.bus.addr[7:0] + 8'h01)};
					end
					s_d.state = ST_PTR_HI;
				end
			end
			ST_PTR_HI:
			begin
				if (cyc_end)
				begin
					s_d.resp.ea = ea_ind;
					if (s_q.rq.kind == K_JUMP || s_q.rq.kind == K_FETCH)
					begin
						s_d.resp.pc = ea_ind;
						s_d.resp.pc_load = 1'b1;
						s_d.resp.done = 1'b1;
						s_d.state = ST_IDLE;
					end
					else
					begin
						s_d.bus.addr = ea_ind;
						s_d.bus.dout = s_q.rq.wdata;
						s_d.bus.rw = (s_q.rq.kind != K_WRITE);
						s_d.state = ST_ACCESS;
					end
				end
			end
			ST_ACCESS:
			begin
				if (cyc_end)
				begin
					s_d.resp.done = 1'b1;
					s_d.resp.rdata = rd_data;
					s_d.bus.rw = 1'b1;
					s_d.state = ST_IDLE;
				end
			end
			ST_PUSH_H:
			begin
				if (!ph1)
				begin
					s_d.sp = s_q.sp - 8'h01;
					s_d.bus.addr = {STACK_PAGE, 8'(s_q.sp - 8'h01)};
					s_d.bus.dout = s_q.rq.pc[7:0];
					s_d.state = ST_PUSH_L;
				end
			end
			ST_PUSH_L:
			begin
				if (!ph1)
				begin
					s_d.sp = s_q.sp - 8'h01;
					s_d.bus.addr = {STACK_PAGE, 8'(s_q.sp - 8'h01)};
					s_d.bus.dout = push_status;
					s_d.state = ST_PUSH_P;
				end
			end
			ST_PUSH_P:
			begin
				if (!ph1)
				begin
					s_d.sp = s_q.sp - 8'h01;
					s_d.mask = 1'b1;
					s_d.bus.addr = s_q.vec;
					s_d.bus.rw = 1'b1;
					s_d.state = ST_VEC_LO;
				end
			end
			ST_VEC_LO:
			begin
				if (cyc_end)
				begin
					s_d.lo = rd_data;
					s_d.bus.addr = s_q.vec + 16'h0001;
					s_d.state = ST_VEC_HI;
				end
			end
			ST_VEC_HI:
			begin
				if (cyc_end)
				begin
					s_d.resp.pc = {rd_data, s_q.lo};
					s_d.resp.pc_load = 1'b1;
					s_d.resp.sp = s_q.sp;
					s_d.resp.int_entry = (s_q.vec != VEC_RST);
					s_d.resp.done = 1'b1;
					s_d.state = ST_IDLE;
				end
			end
			default:
			begin
				s_d.state = ST_IDLE;
			end
		endcase

		// Edge detectors run after the sequencer so a new edge wins
		if (ph1)
		begin
			s_d.so_prev = ovf_set_n;
			if (s_q.so_prev && !ovf_set_n)
			begin
				s_d.ovf = 1'b1;
			end
		end
		else
		begin
			s_d.nmi_prev = nmi_n;
			if (s_q.nmi_prev && !nmi_n)
			begin
				s_d.nmi_pend = 1'b1;
			end
			s_d.irq_lvl = ~irq_n & hold_in;
		end

		// Gate is taken with the next direction, so no overlap with reads
		s_d.oe = data_output_gate & ~s_d.bus.rw;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= CTL_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign bus = s_q.bus;
	assign data_oe = s_q.oe;
	assign phase_two = s_q.ph;
	assign resp = s_q.resp;
	assign mask_flag = s_q.mask;
	assign ovf_flag = s_q.ovf;

endmodule

// ===== logic/cpu_bus_pkg.sv
package cpu_bus_pkg;

	// Fixed vectors, low byte at the even address
	localparam logic [15:0] VEC_NMI = 16'hfffa;
	localparam logic [15:0] VEC_RST = 16'hfffc;
	localparam logic [15:0] VEC_IRQ = 16'hfffe;

	localparam logic [7:0] STACK_PAGE = 8'h01;
	localparam logic [7:0] ZERO_PAGE = 8'h00;

	// Bus cycles of initialisation after reset release
	localparam logic [2:0] RESET_INIT_CYCLES = 3'h6;

	// Positions of the flags kept here inside the pushed status byte
	localparam int STATUS_OVF_BIT = 6;
	localparam int STATUS_MASK_BIT = 2;

	typedef enum logic [1:0] {
		K_FETCH = 2'h0,
		K_READ = 2'h1,
		K_WRITE = 2'h2,
		K_JUMP = 2'h3
	} kind_e;

	typedef enum logic [3:0] {
		M_IMPL = 4'h0,
		M_ABS = 4'h1,
		M_ZP = 4'h2,
		M_ZPX = 4'h3,
		M_ZPY = 4'h4,
		M_ABSX = 4'h5,
		M_ABSY = 4'h6,
		M_REL = 4'h7,
		M_INDX = 4'h8,
		M_INDY = 4'h9,
		M_IND = 4'ha
	} mode_e;

	typedef enum logic [10:0] {
		ST_RST = 11'h001,
		ST_IDLE = 11'h002,
		ST_FETCH = 11'h004,
		ST_PTR_LO = 11'h008,
		ST_PTR_HI = 11'h010,
		ST_ACCESS = 11'h020,
		ST_PUSH_H = 11'h040,
		ST_PUSH_L = 11'h080,
		ST_PUSH_P = 11'h100,
		ST_VEC_LO = 11'h200,
		ST_VEC_HI = 11'h400
	} state_e;

	typedef struct packed {
		logic valid;
		kind_e kind;
		mode_e mode;
		logic [7:0] op_lo;
		logic [7:0] op_hi;
		logic [7:0] idx_x;
		logic [7:0] idx_y;
		logic [15:0] pc;
		logic [7:0] sp;
		logic [7:0] wdata;
		logic [7:0] status;
	} cpu_req_s;

	typedef struct packed {
		logic mask_set;
		logic mask_clr;
		logic ovf_clr;
	} flag_ctrl_s;

	typedef struct packed {
		logic done;
		logic int_entry;
		logic pc_load;
		logic [7:0] rdata;
		logic [15:0] ea;
		logic [15:0] pc;
		logic [7:0] sp;
	} cpu_resp_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dout;
		logic rw;
		logic marker;
	} bus_out_s;

	typedef struct packed {
		state_e state;
		logic ph;
		logic [2:0] init_cnt;
		bus_out_s bus;
		logic oe;
		logic freeze;
		logic mask;
		logic ovf;
		logic nmi_prev;
		logic nmi_pend;
		logic irq_lvl;
		logic so_prev;
		logic [15:0] vec;
		logic [7:0] lo;
		logic [7:0] sp;
		cpu_req_s rq;
		cpu_resp_s resp;
	} ctl_st_s;

	// Read direction and idle inputs high so no edge is seen at release
	localparam ctl_st_s CTL_RESET = '{
		state: ST_RST,
		bus: '{rw: 1'b1, default: '0},
		mask: 1'b1,
		nmi_prev: 1'b1,
		so_prev: 1'b1,
		default: '0
	};

endpackage

// ===== verif/cpu_bus_control_asserts.sv
`timescale 1ns/10ps
module cpu_bus_control_asserts
	import cpu_bus_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic data_output_gate,
	input wire logic hold_in,
	input wire logic ovf_set_n,
	input wire bus_out_s bus,
	input wire logic data_oe,
	input wire logic phase_two,
	input wire cpu_resp_s resp,
	input wire logic mask_flag,
	input wire logic ovf_flag
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	chk_gate_drive: assert property (
		data_oe |-> !bus.rw && $past(data_output_gate))
		else $error("data driven in read or with gate low");
	chk_reset_nowrite: assert property (disable iff (1'b0)
		!arst_n |-> bus.rw && !data_oe)
		else $error("write while reset held");
	chk_hold_stall: assert property (
		bus.marker && !hold_in ##1 bus.marker && !hold_in
		|=> bus.marker && $stable(bus.addr) && !resp.done)
		else $error("fetch moved on while hold low");
	chk_write_nohold: assert property (
		!bus.rw && phase_two
		|=> resp.done || bus.addr != $past(bus.addr))
		else $error("write cycle stalled");
	chk_int_entry: assert property (
		resp.int_entry |-> resp.done && resp.pc_load && mask_flag)
		else $error("entry without mask set");
	chk_vec_addr: assert property (
		resp.int_entry |-> $past(bus.addr) inside {16'hfffb, 16'hffff})
		else $error("entry vector address wrong");
	chk_ovf_set: assert property (
		$fell(ovf_set_n) |-> ##[1:3] ovf_flag)
		else $error("overflow not set");
	chk_marker_fetch: assert property (
		$rose(bus.marker) |-> !phase_two ##1 bus.marker && phase_two)
		else $error("marker not held through fetch");
	chk_reset_vec: assert property (
		$rose(arst_n) |-> (!bus.marker && bus.addr == 16'h0000) [*8]
		##4 !bus.marker ##1 bus.addr == 16'hfffc && mask_flag)
		else $error("reset vector read missing");
endmodule
bind cpu_bus_control cpu_bus_control_asserts u_chk (.sys_clk(sys_clk),
	.arst_n(arst_n), .data_output_gate(data_output_gate),
	.hold_in(hold_in), .ovf_set_n(ovf_set_n), .bus(bus),
	.data_oe(data_oe), .phase_two(phase_two), .resp(resp),
	.mask_flag(mask_flag), .ovf_flag(ovf_flag));

// ===== verif/cpu_bus_mem.sv
`timescale 1ns/10ps
module cpu_bus_mem
	import cpu_bus_pkg::*;
(
	input wire logic sys_clk,
	input wire bus_out_s bus,
	input wire logic data_oe,
	output logic [7:0] rd_data
);
	logic [7:0] mem [65536];
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
	end
	// A byte lands only when the block really drives the bus
	always @(posedge sys_clk)
		if (!bus.rw && data_oe)
			mem[bus.addr] <= bus.dout;
	// No stale byte during writes, so a misplaced read shows up
	assign rd_data = bus.rw ? mem[bus.addr] : ~bus.addr[7:0];
endmodule

// ===== verif/tb_cpu_bus_control.sv
`timescale 1ns/10ps
module tb_cpu_bus_control
	import cpu_bus_pkg::*;
();
	// Starts high so the first low drive is a real edge for the reset
	logic sys_clk = 1'b0, arst_n = 1'b1, data_output_gate = 1'b1;
	logic hold_in = 1'b1, irq_n = 1'b1, nmi_n = 1'b1, ovf_set_n = 1'b1;
	logic [7:0] rd_data, lo, hi, x, y;
	logic [15:0] pc;
	logic [17:0] exp_notes [$];
	cpu_req_s req = '0;
	flag_ctrl_s flag_ctrl = '0;
	bus_out_s bus;
	cpu_resp_s resp;
	logic data_oe, phase_two, mask_flag, ovf_flag;
	int err_total = 0, tests_run = 0, seed = 44, hmode = 1;
	always #5 sys_clk = ~sys_clk;
	cpu_bus_control u_cpu_bus_control (.sys_clk(sys_clk),
		.arst_n(arst_n), .data_output_gate(data_output_gate),
		.hold_in(hold_in), .irq_n(irq_n), .nmi_n(nmi_n),
		.ovf_set_n(ovf_set_n), .rd_data(rd_data), .req(req),
		.flag_ctrl(flag_ctrl), .bus(bus), .data_oe(data_oe),
		.phase_two(phase_two), .resp(resp), .mask_flag(mask_flag),
		.ovf_flag(ovf_flag));
	cpu_bus_mem u_cpu_bus_mem (.sys_clk(sys_clk), .bus(bus),
		.data_oe(data_oe), .rd_data(rd_data));
	// Mode 0 holds low, 1 random, 2 high
	always @(negedge sys_clk)
	begin
		hold_in <= hmode == 1 ? $random(seed) % 4 != 0 : hmode == 2;
		data_output_gate <= 1'($random(seed));
	end
	function automatic logic [7:0] mb(logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	// Top two bits pick the field: 0 ea, 1 pc, 2 read data
	function automatic logic [17:0] expv(mode_e m);
		logic [7:0] p;
		p = m == M_INDX ? 8'(lo + x) : lo;
		case (m)
			M_ABS: return {2'h0, hi, lo};
			M_ZP: return {2'h0, 8'h0, lo};
			M_ZPX: return {2'h0, 8'h0, 8'(lo + x)};
			M_ZPY: return {2'h0, 8'h0, 8'(lo + y)};
			M_ABSX: return {2'h0, 16'({hi, lo} + x)};
			M_ABSY: return {2'h0, 16'({hi, lo} + y)};
			M_REL: return {2'h1, 16'(pc + {{8{lo[7]}}, lo})};
			M_INDX: return {2'h0, mb({8'h0, 8'(p + 1)}), mb({8'h0, p})};
			M_INDY: return {2'h0,
				16'({mb({8'h0, 8'(p + 1)}), mb({8'h0, p})} + y)};
			M_IND: return {2'h1, mb({hi, lo} + 16'h1), mb({hi, lo})};
			default: return '0;
		endcase
	endfunction
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_q();
		int n;
		for (n = 0; n < 400 && exp_notes.size() != 0; n++)
			@(negedge sys_clk);
		if (n == 400)
		begin
			err_total++;
			stop_test();
		end
	endtask
	task automatic do_req(kind_e k, mode_e m, logic [17:0] e);
		int n;
		exp_notes.push_back(e);
		req <= '{1'b1, k, m, lo, hi, x, y, pc, 8'hf0, lo, hi};
		for (n = 0; n < 400 && resp.done !== 1'b1; n++)
			@(negedge sys_clk);
		if (n == 400)
		begin
			err_total++;
			stop_test();
		end
		req.valid <= 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	always @(negedge sys_clk)
		if (resp.done === 1'b1)
		begin
			if (exp_notes.size() == 0)
				chk("spare done", 16'h0, 16'h1);
			else
				case (exp_notes[0][17:16])
					2'h0: chk("ea", exp_notes[0][15:0], resp.ea);
					2'h1: chk("pc", exp_notes[0][15:0], resp.pc);
					default: chk("rdata", exp_notes[0][15:0], 16'(resp.rdata));
				endcase
			if (exp_notes.size() != 0)
				void'(exp_notes.pop_front());
		end
	task automatic do_reset(int len);
		arst_n <= 1'b0;
		exp_notes.push_back({2'h1, mb(16'hfffd), mb(16'hfffc)});
		repeat (len) @(negedge sys_clk);
		arst_n <= 1'b1;
		wait_q();
		chk("mask", 16'h1, 16'(mask_flag));
	endtask
	initial
	begin
		do_reset(6);
		irq_n <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			pc = 16'($random(seed));
			// Masked request must not divert the fetch
			do_req(K_FETCH, M_IMPL, {2'h2, 8'h0, mb(pc)});
		end
		irq_n <= 1'b1;
		hmode = 0;
		fork
			begin
				repeat (12) @(negedge sys_clk);
				hmode = 1;
			end
		join_none
		do_req(K_FETCH, M_IMPL, {2'h2, 8'h0, mb(pc)});
		for (int r = 0; r < 20; r++)
		begin
			{lo, hi, x, y, pc} = 48'({$random(seed), $random(seed)});
			do_req(r % 10 == 6 || r % 10 == 9 ? K_JUMP : K_READ,
				mode_e'(r % 10 + 1), expv(mode_e'(r % 10 + 1)));
		end
		lo = 8'($random(seed));
		hi = 8'h20;
		do_req(K_WRITE, M_ABS, {2'h0, hi, lo});
		ovf_set_n <= 1'b0;
		repeat (3) @(negedge sys_clk);
		ovf_set_n <= 1'b1;
		chk("ovf", 16'h1, 16'(ovf_flag));
		hmode = 2;
		flag_ctrl <= '{mask_clr: 1'b1, default: '0};
		// Request must be seen in a phase two before the fetch is taken
		irq_n <= 1'b0;
		@(negedge sys_clk);
		flag_ctrl <= '0;
		repeat (3) @(negedge sys_clk);
		do_req(K_FETCH, M_IMPL, {2'h1, mb(16'hffff), mb(16'hfffe)});
		irq_n <= 1'b1;
		chk("mask", 16'h1, 16'(mask_flag));
		chk("sp", 16'h00ed, 16'(resp.sp));
		nmi_n <= 1'b0;
		repeat (2) @(negedge sys_clk);
		do_req(K_FETCH, M_IMPL, {2'h1, mb(16'hfffb), mb(16'hfffa)});
		nmi_n <= 1'b1;
		do_reset(3);
		stop_test();
	end
endmodule
